// file: pss_host_model.sv
// host side: chip enable, select pins and wake sources
`timescale 1ns/1ps
module pss_host_model (
  input logic clk,
  output logic ce,
  output logic [1:0] sel,
  output logic [3:0] ev
);
  initial begin
    ce = 1'b0;
    sel = 2'h0;
    ev = 4'h0;
  end
  // selects settle one cycle before chip enable rises
  task automatic boot(input logic [1:0] s);
    @(posedge clk) sel <= s;
    @(posedge clk) ce <= 1'b1;
  endtask
  task automatic off();
    @(posedge clk) ce <= 1'b0;
  endtask
  task automatic low(input int n);
    off();
    repeat (n) @(posedge clk);
    ce <= 1'b1;
  endtask
  // ev bits: host, poll, card, field
  task automatic pulse(input int b);
    @(posedge clk) ev[b] <= 1'b1;
    @(posedge clk) ev[b] <= 1'b0;
  endtask
endmodule // pss_host_model

// file: pss_pkg.sv
// types shared by the power state sequencer
package pss_pkg;
  typedef enum logic [5:0] {
    PSS_ST_PD      = 6'h01,
    PSS_ST_RESET   = 6'h02,
    PSS_ST_RAMP    = 6'h04,
    PSS_ST_ACTIVE  = 6'h08,
    PSS_ST_STANDBY = 6'h10,
    PSS_ST_WAKE    = 6'h20
  } pss_state_e;
  typedef logic [2:0] pss_wake_t;
endpackage

// file: pss_power_state_sequencer.sv
// energy state, boot and clock source control driven by chip enable
`timescale 1ns/1ps
`include "pss_regs.svh"
module pss_power_state_sequencer #(
  parameter int unsigned PD_LOW_CYC = `PSS_PD_CYC,
  // ticks of the low-power clock before ready; at most 256
  parameter int unsigned READY_TICKS = `PSS_READY_TICKS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic chipEnableIn,
  input wire logic ifaceSelectBit1,
  input wire logic ifaceSelectBit2,
  input wire logic hostActivity,
  input wire logic pollEvent,
  input wire logic lowPowerCardDetect,
  input wire logic lowPowerFieldDetect,
  input wire logic [1:0] wakeSrcEn,
  input wire logic standbyReq,
  input wire logic pllLock,
  input wire logic extRefReq,
  input wire logic [7:0] gpioOeReq,
  input wire logic [15:0] dsmFrac,
  input wire logic [7:0] dsmInt,
  output pss_pkg::pss_state_e stateOut,
  output logic coreRstN,
  output logic supplyEn,
  output logic lowPowerOscTick,
  output logic crystalOscEn,
  output logic extRefSel,
  output logic pllEn,
  output logic sysClkSelPll,
  output logic hostIfaceEn,
  output logic [1:0] ifaceSel,
  output logic sifPadEn,
  output logic [7:0] gpioOe,
  output logic readyOut,
  output logic wakeEvent,
  output pss_pkg::pss_wake_t wakeCause,
  output logic [7:0] pllDivN
);
  import pss_pkg::*;

  localparam logic [15:0] IGN_CYC = 16'(`PSS_IGNORE_CYC);
  localparam logic [15:0] PD_CYC = 16'(PD_LOW_CYC);
  localparam logic [10:0] LPO_LAST = 11'(`PSS_LPO_DIV - 1);
  localparam logic [7:0] READY_LAST = 8'(READY_TICKS - 1);

  // chip enable input side
  logic ceMeta_reg;
  logic ceSync_reg;
  logic [15:0] lowCnt_reg;
  logic [15:0] lowCnt_next;
  logic [10:0] lpoCnt_reg;
  logic [10:0] lpoCnt_next;
  logic lpoTick_next;

  // filter runs on clk gated by clkEn, not the pll
  always_comb begin
    lowCnt_next = lowCnt_reg;
    if (ceSync_reg) begin
      lowCnt_next = 16'h0000; // RL18
    end else if (lowCnt_reg != 16'hffff) begin
      lowCnt_next = lowCnt_reg + 16'h0001; // RL18
    end
    lpoTick_next = (lpoCnt_reg == LPO_LAST);
    lpoCnt_next = lpoTick_next ? 11'h000 : lpoCnt_reg + 11'h001;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ceMeta_reg <= 1'b0;
      ceSync_reg <= 1'b0;
      lowCnt_reg <= 16'h0000;
      lpoCnt_reg <= 11'h000;
      lowPowerOscTick <= 1'b0;
    end else if (clkEn) begin
      ceMeta_reg <= chipEnableIn; // RL18
      ceSync_reg <= ceMeta_reg;
      lowCnt_reg <= lowCnt_next;
      lpoCnt_reg <= lpoCnt_next;
      lowPowerOscTick <= lpoTick_next; // RL13
    end
  end

  // pulse classification: reset from the low time just ended, power-down while still low
  logic lowEnded;
  logic resetPulse;
  logic pdHit;
  assign lowEnded = ceSync_reg && (lowCnt_reg != 16'h0000);
  // short pulses fall through and change nothing
  assign resetPulse = lowEnded && (lowCnt_reg >= IGN_CYC) &&
                      (lowCnt_reg < PD_CYC); // RL3 RL4
  assign pdHit = !ceSync_reg && (lowCnt_reg >= PD_CYC); // RL4

  // state machine and its registered outputs
  pss_state_e state_reg;
  pss_state_e state_next;
  logic boot_reg;
  logic boot_next;
  logic [7:0] readyCnt_reg;
  logic [7:0] readyCnt_next;
  logic [1:0] ifaceSel_next;
  logic wakeAny;
  pss_wake_t cause;
  pss_wake_t wakeCause_next;
  logic coreRstN_next;
  logic supplyEn_next;
  logic xoEn_next;
  logic extRef_next;
  logic pllEn_next;
  logic clkSel_next;
  logic hostEn_next;
  logic sifEn_next;
  logic [7:0] gpioOe_next;
  logic ready_next;
  logic wakeEvent_next;

  always_comb begin
    cause = {(lowPowerCardDetect | lowPowerFieldDetect) &
               wakeSrcEn[`PSS_WAKE_DETECT_BIT],
             pollEvent & wakeSrcEn[`PSS_WAKE_POLL_BIT],
             hostActivity}; // RL12
    wakeAny = |cause;
    state_next = state_reg;
    boot_next = boot_reg;
    readyCnt_next = readyCnt_reg;
    ifaceSel_next = ifaceSel;
    wakeCause_next = wakeCause;
    wakeEvent_next = 1'b0;
    unique case (state_reg)
      PSS_ST_PD: begin
        // nothing but chip enable is looked at here
        if (ceSync_reg) begin
          state_next = PSS_ST_RESET; // RL2
          boot_next = 1'b1;
        end
      end
      PSS_ST_RESET: begin
        state_next = PSS_ST_RAMP;
        readyCnt_next = 8'h00;
        if (boot_reg) begin
          // host has these stable by now
          ifaceSel_next = {ifaceSelectBit2, ifaceSelectBit1}; // RL7 RL8 RL9
          boot_next = 1'b0;
        end
      end
      PSS_ST_RAMP: begin
        if (lpoTick_next && readyCnt_reg != READY_LAST) begin
          readyCnt_next = readyCnt_reg + 8'h01; // RL13
        end
        if (readyCnt_reg == READY_LAST && pllLock) begin
          state_next = PSS_ST_ACTIVE; // RL10
        end
      end
      PSS_ST_ACTIVE: begin
        if (standbyReq) begin
          state_next = PSS_ST_STANDBY;
        end
      end
      PSS_ST_STANDBY: begin
        if (wakeAny) begin
          state_next = PSS_ST_WAKE; // RL12
          wakeCause_next = cause;
          wakeEvent_next = 1'b1;
        end
      end
      PSS_ST_WAKE: begin
        // no reset on this path: context survives standby
        if (pllLock) begin
          state_next = PSS_ST_ACTIVE; // RL11
        end
      end
      default: begin
        state_next = PSS_ST_PD;
      end
    endcase
    // chip enable overrides everything but a short glitch
    if (state_reg != PSS_ST_PD) begin
      if (pdHit) begin
        state_next = PSS_ST_PD; // RL2 RL4
        wakeEvent_next = 1'b0;
      end else if (resetPulse) begin
        state_next = PSS_ST_RESET; // RL4
        wakeEvent_next = 1'b0;
      end
    end
    if (state_next == PSS_ST_PD) begin
      wakeCause_next = 3'h0; // RL6
    end
    supplyEn_next = (state_next != PSS_ST_PD); // RL2
    coreRstN_next = !(state_next == PSS_ST_PD ||
                      state_next == PSS_ST_RESET); // RL6
    pllEn_next = (state_next == PSS_ST_RAMP ||
                  state_next == PSS_ST_ACTIVE ||
                  state_next == PSS_ST_WAKE); // RL13 RL14
    xoEn_next = pllEn_next && !extRefReq; // RL15
    extRef_next = pllEn_next && extRefReq; // RL15
    clkSel_next = (state_next == PSS_ST_ACTIVE); // RL1 RL13
    hostEn_next = (state_next == PSS_ST_ACTIVE); // RL1
    ready_next = (state_next == PSS_ST_ACTIVE); // RL10
    sifEn_next = (state_next != PSS_ST_PD); // RL5
    // general-purpose pads stay released in power-down, reset and ramp
    gpioOe_next = 8'h00;
    if (state_next == PSS_ST_ACTIVE || state_next == PSS_ST_STANDBY ||
        state_next == PSS_ST_WAKE) begin
      gpioOe_next = gpioOeReq;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= PSS_ST_PD;
      stateOut <= PSS_ST_PD;
      boot_reg <= 1'b0;
      readyCnt_reg <= 8'h00;
      ifaceSel <= 2'h0;
      wakeCause <= 3'h0;
      wakeEvent <= 1'b0;
      coreRstN <= 1'b0;
      supplyEn <= 1'b0;
      crystalOscEn <= 1'b0;
      extRefSel <= 1'b0;
      pllEn <= 1'b0;
      sysClkSelPll <= 1'b0;
      hostIfaceEn <= 1'b0;
      sifPadEn <= 1'b0;
      gpioOe <= 8'h00;
      readyOut <= 1'b0;
    end else if (clkEn) begin
      state_reg <= state_next;
      stateOut <= state_next;
      boot_reg <= boot_next;
      readyCnt_reg <= readyCnt_next;
      ifaceSel <= ifaceSel_next;
      wakeCause <= wakeCause_next;
      wakeEvent <= wakeEvent_next;
      coreRstN <= coreRstN_next;
      supplyEn <= supplyEn_next;
      crystalOscEn <= xoEn_next;
      extRefSel <= extRef_next;
      pllEn <= pllEn_next;
      sysClkSelPll <= clkSel_next;
      hostIfaceEn <= hostEn_next;
      sifPadEn <= sifEn_next;
      gpioOe <= gpioOe_next; // RL5
      readyOut <= ready_next;
    end
  end

  // first-order delta-sigma: carry dithers the integer divide
  logic [15:0] dsmAcc_reg;
  logic [15:0] dsmAcc_next;
  logic [7:0] pllDivN_next;
  logic [16:0] dsmSum;

  always_comb begin
    dsmSum = {1'b0, dsmAcc_reg} + {1'b0, dsmFrac};
    dsmAcc_next = dsmAcc_reg;
    pllDivN_next = pllDivN;
    if (pllEn) begin
      dsmAcc_next = dsmSum[15:0]; // RL16
      pllDivN_next = dsmInt + {7'h00, dsmSum[16]}; // RL16 RL14
    end else begin
      // restart from a known phase on every pll power-up
      dsmAcc_next = 16'h0000;
      pllDivN_next = dsmInt;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dsmAcc_reg <= 16'h0000;
      pllDivN <= 8'h00;
    end else if (clkEn) begin
      dsmAcc_reg <= dsmAcc_next;
      pllDivN <= pllDivN_next;
    end
  end
endmodule // pss_power_state_sequencer

// file: pss_power_state_sequencer_monitor.sv
// port-level assertions for the power state sequencer
`timescale 1ns/1ps
module pss_power_state_sequencer_monitor import pss_pkg::*; #(
  parameter int unsigned PD_LOW_CYC = 1000
) (
  input logic clk,
  input logic arst_n,
  input pss_pkg::pss_state_e stateOut,
  input logic coreRstN,
  input logic supplyEn,
  input logic sifPadEn,
  input logic [7:0] gpioOe,
  input logic hostIfaceEn,
  input logic sysClkSelPll,
  input logic pllEn,
  input logic crystalOscEn,
  input logic extRefSel,
  input logic [1:0] ifaceSel,
  input logic wakeEvent
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_pd; stateOut == PSS_ST_PD |-> !sifPadEn && gpioOe == 8'h00;
  endproperty
  a_pd: assert property (p_pd) else $error("pads driven in pd");
  property p_sup; supplyEn == (stateOut != PSS_ST_PD); endproperty
  a_sup: assert property (p_sup) else $error("supply mismatch");
  property p_hif; hostIfaceEn == (stateOut == PSS_ST_ACTIVE); endproperty
  a_hif: assert property (p_hif) else $error("host iface mismatch");
  property p_standby_state; stateOut == PSS_ST_STANDBY |-> !pllEn && !sysClkSelPll;
  endproperty
  a_standby_state: assert property (p_standby_state) else $error("pll in standby");
  property p_ref; !(crystalOscEn && extRefSel); endproperty
  a_ref: assert property (p_ref) else $error("two references");
  property p_rst; stateOut == PSS_ST_RESET |-> !coreRstN; endproperty
  a_rst: assert property (p_rst) else $error("core not reset");
  property p_sel; stateOut != PSS_ST_RESET |=> $stable(ifaceSel); endproperty
  a_sel: assert property (p_sel) else $error("select moved");
  property p_wk;
    wakeEvent |-> stateOut == PSS_ST_WAKE && $past(stateOut) == PSS_ST_STANDBY
    ##1 !wakeEvent;
  endproperty
  a_wk: assert property (p_wk) else $error("bad wake pulse");
  c_act: cover property (stateOut == PSS_ST_ACTIVE);
  c_standby_state: cover property (stateOut == PSS_ST_STANDBY);
  c_wake: cover property (wakeEvent);
endmodule // pss_power_state_sequencer_monitor
bind pss_power_state_sequencer pss_power_state_sequencer_monitor #(
  .PD_LOW_CYC(PD_LOW_CYC)) u_pss_power_state_sequencer_monitor (.*);

// file: pss_power_state_sequencer_tb.sv
// self-checking bench for the power state sequencer
`timescale 1ns/1ps
module pss_power_state_sequencer_tb;
  import pss_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, pllLock = 1'b0, extRefReq = 1'b0;
  logic standbyReq = 1'b0, ce, coreRstN, supplyEn, crystalOscEn, extRefSel;
  logic clkEn = 1'b1, lowPowerOscTick;
  int cyc = 0, lastCyc = 0, nTicks = 0;
  logic pllEn, sysClkSelPll, hostIfaceEn, sifPadEn, readyOut, wakeEvent;
  logic [1:0] sel, ifaceSel, wakeSrcEn = 2'h1;
  logic [3:0] ev;
  logic [7:0] gpioOeReq = 8'h00, dsmInt = 8'h00, gpioOe;
  logic [15:0] dsmFrac = 16'h0000;
  pss_wake_t wakeCause;
  pss_state_e stateOut, lastSt = PSS_ST_PD, expQ[$];
  int seed = 95, nErrors = 0, totalChecks = 0;
  pss_host_model u_pss_host_model (.clk(clk), .ce(ce), .sel(sel), .ev(ev));
  // short ready time keeps the run small; the counting logic is the same
  pss_power_state_sequencer #(.PD_LOW_CYC(1000), .READY_TICKS(20))
    u_pss_power_state_sequencer (
    .clk(clk), .arst_n(arst_n), .clkEn(clkEn), .chipEnableIn(ce),
    .ifaceSelectBit1(sel[0]), .ifaceSelectBit2(sel[1]), .hostActivity(ev[0]),
    .pollEvent(ev[1]), .lowPowerCardDetect(ev[2]),
    .lowPowerFieldDetect(ev[3]), .wakeSrcEn(wakeSrcEn),
    .standbyReq(standbyReq), .pllLock(pllLock), .extRefReq(extRefReq),
    .gpioOeReq(gpioOeReq), .dsmFrac(dsmFrac), .dsmInt(dsmInt),
    .stateOut(stateOut), .coreRstN(coreRstN), .supplyEn(supplyEn),
    .lowPowerOscTick(lowPowerOscTick), .crystalOscEn(crystalOscEn),
    .extRefSel(extRefSel),
    .pllEn(pllEn), .sysClkSelPll(sysClkSelPll), .hostIfaceEn(hostIfaceEn),
    .ifaceSel(ifaceSel), .sifPadEn(sifPadEn), .gpioOe(gpioOe),
    .readyOut(readyOut), .wakeEvent(wakeEvent), .wakeCause(wakeCause),
    .pllDivN());
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    gpioOeReq <= 8'($random(seed));
    dsmFrac <= 16'($random(seed));
    dsmInt <= 8'($random(seed));
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    totalChecks++;
    if (g !== e) begin
      nErrors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic closeOut();
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // tick spacing counted only over enabled edges
  always @(posedge clk) begin
    if (arst_n && clkEn) cyc <= cyc + 1;
  end
  always @(negedge clk) begin
    if (arst_n && lowPowerOscTick && cyc != lastCyc) begin
      if (nTicks > 0) chk("tickGap", 8'h01, 8'(cyc - lastCyc == 2000));
      lastCyc = cyc;
      nTicks++;
    end
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic note(input pss_state_e a, input pss_state_e b);
    expQ.push_back(a);
    expQ.push_back(b);
  endtask
  // any state change not announced in advance is a mismatch
  always @(negedge clk) begin
    if (arst_n && stateOut !== lastSt) begin
      if (expQ.size() == 0) chk("stateOut", 8'h00, stateOut);
      else chk("stateOut", expQ.pop_front(), stateOut);
      lastSt = stateOut;
    end
  end
  initial begin
    w(4);
    arst_n <= 1'b1;
    w(2);
    chk("pads", {sifPadEn, gpioOe[6:0]}, 8'h00);
    u_pss_host_model.pulse(0);
    note(PSS_ST_RESET, PSS_ST_RAMP);
    u_pss_host_model.boot(2'h1);
    w(10);
    chk("ifaceSel", 8'h01, ifaceSel);
    u_pss_host_model.boot(2'h2);
    u_pss_host_model.low(800);
    note(PSS_ST_RESET, PSS_ST_RAMP);
    u_pss_host_model.low(900);
    w(10);
    chk("ifaceSel", 8'h01, ifaceSel);
    expQ.push_back(PSS_ST_PD);
    u_pss_host_model.off();
    w(1100);
    u_pss_host_model.pulse(1);
    chk("supplyEn", 8'h00, supplyEn);
    note(PSS_ST_RESET, PSS_ST_RAMP);
    u_pss_host_model.boot(2'h2);
    w(10);
    chk("ifaceSel", 8'h02, ifaceSel);
    expQ.push_back(PSS_ST_ACTIVE);
    @(posedge clk) pllLock <= 1'b1;
    for (int i = 0; i < 100000 && readyOut !== 1'b1; i++) @(posedge clk);
    w(1);
    chk("hostIfaceEn", 8'h01, hostIfaceEn);
    chk("sysClkSelPll", 8'h01, sysClkSelPll);
    @(posedge clk) extRefReq <= 1'b1;
    w(3);
    chk("extRefSel", 8'h01, {crystalOscEn, extRefSel});
    note(PSS_ST_STANDBY, PSS_ST_WAKE);
    expQ.push_back(PSS_ST_ACTIVE);
    @(posedge clk) wakeSrcEn <= 2'h3;
    @(posedge clk) standbyReq <= 1'b1;
    @(posedge clk) standbyReq <= 1'b0;
    w(3);
    chk("pllEn", 8'h00, pllEn);
    u_pss_host_model.pulse(1);
    w(4);
    chk("wakeCause", 8'h02, wakeCause);
    chk("ifaceSel", 8'h02, ifaceSel);
    // frozen clock enable must hold off a standby request
    @(posedge clk) clkEn <= 1'b0;
    standbyReq <= 1'b1;
    w(5);
    chk("frozenState", 8'h08, 8'(stateOut));
    @(posedge clk) standbyReq <= 1'b0;
    @(posedge clk) clkEn <= 1'b1;
    w(3);
    chk("resumedState", 8'h08, 8'(stateOut));
    chk("queue", 8'h00, 8'(expQ.size()));
    closeOut();
  end
  // full run is about 40k cycles
  initial begin
    #400000;
    nErrors++;
    closeOut();
  end
endmodule // pss_power_state_sequencer_tb

// file: pss_regs.svh
// timing constants and behaviour summary for the power state sequencer
// Behaviour
// RL1 - chip enable high: full power, all clocks running, host interface accepted
// RL2 - chip enable low: power-down, lowest consumption, every external event ignored
// RL3 - chip enable low pulses under 3.4 us leave the energy state unchanged
// RL4 - slightly longer low pulse resets internal state; longer one enters power-down
// RL5 - power-down puts general-purpose and interface-select pads into high impedance
// RL6 - leaving power-down starts from fully reset state, no context kept
// RL7 - interface-select pins sampled only at boot; later changes ignored
// RL8 - host keeps pad supply and select pins stable by chip enable high
// RL9 - with chip enable on battery, supplies and selects settle within 100 us
// RL10 - ready for operation under 1 ms after inputs are stable
// RL11 - standby keeps chip enable high and whole internal state intact
// RL12 - standby left on host activity, polling or card/field detection
// RL13 - ramp-up and standby run control logic from the 125 kHz oscillator
// RL14 - PLL derives the 13.56 MHz system clock from crystal or external reference
// RL15 - external reference 13.15 to 52 MHz on crystal input, else 27.12 MHz crystal
// RL16 - delta-sigma modulator supplies the fractional-N PLL division word
// RL17 - host drops chip enable before battery falls below its minimum
// RL18 - chip enable synchronised and low time measured on the free-running clock; here both advance only on clk edges with clkEn high
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
`define PSS_CLK_MHZ 250
`define PSS_IGNORE_TIME_NS 3400
`define PSS_IGNORE_CYC ((`PSS_IGNORE_TIME_NS*`PSS_CLK_MHZ+999)/1000)
`define PSS_PD_TIME_NS 20000
`define PSS_PD_CYC ((`PSS_PD_TIME_NS*`PSS_CLK_MHZ+999)/1000)
`define PSS_LPO_KHZ 125
`define PSS_LPO_DIV (`PSS_CLK_MHZ*1000/`PSS_LPO_KHZ)
`define PSS_READY_TIME_US 1000
`define PSS_READY_TICKS (`PSS_READY_TIME_US*`PSS_LPO_KHZ/1000)
`define PSS_WAKE_POLL_BIT 0
`define PSS_WAKE_DETECT_BIT 1
`endif
